//--- bench/ldms_checker.sv
// Purpose: concurrent checks on the ports of the mode sequencer
// Assumes: pins are held steady for three sys cycles around a decision
// Notes:   bound into every ldms_top instance
`timescale 1ns/1ps

module ldms_checker
  import ldms_pkg::*;
(
  // clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  rst_n_i,
  // pins and control
  input wire logic                  en_pin_i,
  input wire logic                  supply_low_lockout_i,
  input wire logic                  temp_hot_i,
  input wire logic                  temp_cool_i,
  input wire ldms_pkg::ldms_ctrl_s  ctrl_i,
  input wire logic                  rst_reg_wr_i,
  // observed outputs
  input wire ldms_pkg::ldms_mode_e  mode_o,
  input wire ldms_pkg::ldms_drive_s drive_o,
  input wire logic                  reg_access_o,
  input wire logic                  bus_busy_o,
  input wire logic                  start_o,
  input wire logic                  stop_o,
  input wire logic                  rep_start_o
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // enabled, supply fine, not hot, no reset register write
  logic quiet_w;
  assign quiet_w = en_pin_i && !supply_low_lockout_i && !temp_hot_i && !rst_reg_wr_i;

  // ==========================================================
  // mode transitions
  a_en_low_shut: assert property (!en_pin_i [*3] |=> mode_o == LDMS_SHUTDOWN)
    else $error("enable low did not give shutdown");
  a_lowv_init: assert property ((en_pin_i && supply_low_lockout_i) [*3] |=> mode_o == LDMS_INIT)
    else $error("supply low did not hold init");
  a_run_normal: assert property (quiet_w [*3] ##0 mode_o == LDMS_STANDBY && ctrl_i.chip_run_en
      |=> mode_o == LDMS_NORMAL)
    else $error("run enable did not give normal");
  a_stop_standby: assert property (quiet_w [*3] ##0 mode_o == LDMS_NORMAL && !ctrl_i.chip_run_en
      |=> mode_o == LDMS_STANDBY)
    else $error("run disable did not give standby");
  a_hot_tsd: assert property ((en_pin_i && !supply_low_lockout_i && temp_hot_i && !rst_reg_wr_i) [*3]
      ##0 mode_o == LDMS_NORMAL |=> mode_o == LDMS_TSD)
    else $error("over temperature did not give thermal shutdown");
  a_cool_normal: assert property ((quiet_w && temp_cool_i) [*3] ##0 mode_o == LDMS_TSD
      |=> mode_o == LDMS_NORMAL)
    else $error("cooling did not return to normal");
  a_wake_normal: assert property (mode_o == LDMS_PSAVE && start_o && ctrl_i.chip_run_en && quiet_w
      |-> ##[1:2] mode_o == LDMS_NORMAL)
    else $error("bus start did not wake");
  // ==========================================================
  // drive decode and framing
  a_sink_mode: assert property (drive_o.led_sink_output_en == (mode_o == LDMS_NORMAL))
    else $error("sinks on outside normal");
  a_regs_rst: assert property (drive_o.regs_rst == (mode_o == LDMS_INIT))
    else $error("register reset not tied to init");
  a_psave_dark: assert property (mode_o == LDMS_PSAVE |-> !drive_o.analog_en && reg_access_o)
    else $error("power save analog or access wrong");
  a_cur_range: assert property ($stable(ctrl_i.cur_range_sel) && mode_o == LDMS_NORMAL
      |-> drive_o.cur_limit == (ctrl_i.cur_range_sel ? CUR_HI_DMA : CUR_LO_DMA))
    else $error("current ceiling does not follow range bit");
  a_start_busy: assert property (start_o |-> bus_busy_o)
    else $error("start without busy");
  a_stop_free: assert property (stop_o |-> ##[0:4] !bus_busy_o)
    else $error("bus still busy after stop");
  a_rep_start: assert property (rep_start_o |-> start_o)
    else $error("repeated start not seen as start");
  // main scenarios reached
  c_psave: cover property (mode_o == LDMS_PSAVE);
  c_tsd: cover property (mode_o == LDMS_TSD);
  c_rep: cover property (rep_start_o);
endmodule // ldms_checker

bind ldms_top ldms_checker u_chk (.clk_sys_i, .rst_n_i, .en_pin_i, .supply_low_lockout_i,
  .temp_hot_i, .temp_cool_i, .ctrl_i, .rst_reg_wr_i, .mode_o, .drive_o, .reg_access_o,
  .bus_busy_o, .start_o, .stop_o, .rep_start_o);

//--- bench/ldms_i2c_master.sv
// Purpose: behavioural two wire bus master on the far side
// Assumes: lines have pull-ups, the sequencer never drives them
// Notes:   q is a quarter bit time in ns, callers pick fast or slow
`timescale 1ns/1ps

module ldms_i2c_master (
  // bus lines, high means released to the pull-up
  output logic scl_o,
  output logic sda_o
);
  // ==========================================================
  // idle bus
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // start or repeated start: data falls while clock high
  task automatic start(input int unsigned q);
    sda_o = 1'b1;
    #(q) scl_o = 1'b1;
    #(q) sda_o = 1'b0;
    #(q) scl_o = 1'b0;
    #(q);
  endtask
  // byte msb first, then a released ack slot; data moves with clock low only
  task automatic wbyte(input logic [7:0] b, input int unsigned q);
    for (int i = 8; i >= 0; i--) begin
      sda_o = (i == 0) ? 1'b1 : b[i-1];
      #(q) scl_o = 1'b1;
      #(2*q) scl_o = 1'b0;
      #(q);
    end
  endtask
  // stop: data rises while clock high, bus left released
  task automatic stop(input int unsigned q);
    sda_o = 1'b0;
    #(q) scl_o = 1'b1;
    #(q) sda_o = 1'b1;
    #(q);
  endtask
endmodule // ldms_i2c_master

//--- bench/testbench.sv
// Purpose: self checking bench of the led driver mode sequencer
// Assumes: off timer shortened to 50 cycles
// Notes:   inputs change on falling sys edges
`timescale 1ns/1ps

module testbench;
  import ldms_pkg::*;
  localparam int unsigned OFFC = 50;
  // ==========================================================
  // stimulus and observed signals
  logic        clk_sys_i = 1'b0, clk_link_i = 1'b0, rst_n_i = 1'b0;
  logic        en_pin_i = 1'b0, supply_low_lockout_i = 1'b0, rst_reg_wr_i = 1'b0;
  logic        temp_hot_i = 1'b0, temp_cool_i = 1'b0, scl, sda;
  logic [7:0]  rst_reg_data_i = 8'h00;
  logic [23:0] act = 24'h000000;
  ldms_ctrl_s  ctrl_i = '0;
  ldms_mode_e  mode_o;
  ldms_drive_s drive_o;
  logic        reg_access_o, sleep_armed_o, bus_busy_o, start_o, stop_o, rep_start_o;
  int          errors = 0, checks = 0, n_sta = 0, n_sto = 0, n_rep = 0;

  // clocks, link clock unrelated in phase
  always #5 clk_sys_i = ~clk_sys_i;
  initial begin
    #33;
    forever #80 clk_link_i = ~clk_link_i;
  end
  ldms_top #(.OFF_CYCLES_P(OFFC)) dut (.clk_sys_i, .rst_n_i,
    .clk_link_i, .en_pin_i, .supply_low_lockout_i, .temp_hot_i, .temp_cool_i, .scl_i(scl),
    .sda_i(sda), .ctrl_i, .rst_reg_wr_i, .rst_reg_data_i, .led_sink_output_act_i(act), .mode_o,
    .drive_o, .reg_access_o, .sleep_armed_o, .bus_busy_o, .start_o, .stop_o, .rep_start_o);
  ldms_i2c_master m (.scl_o(scl), .sda_o(sda));
  // framing pulse counters, sampled away from the launching edge
  always @(negedge clk_sys_i) begin
    if (start_o === 1'b1) n_sta++;
    if (stop_o === 1'b1) n_sto++;
    if (rep_start_o === 1'b1) n_rep++;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_mode(input ldms_mode_e md, input int n);
    for (int i = 0; i < n && mode_o !== md; i++) @(negedge clk_sys_i);
  endtask
  task automatic soft_wr(input logic [7:0] d);
    rst_reg_data_i = d;
    rst_reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    rst_reg_wr_i = 1'b0;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_power();
    repeat (5) @(negedge clk_sys_i);
    check(mode_o, LDMS_SHUTDOWN, "shutdown at power up");
    en_pin_i = 1'b1;
    wait_mode(LDMS_INIT, 8);
    check({mode_o, drive_o.regs_rst}, {LDMS_INIT, 1'b1}, "init resets");
    wait_mode(LDMS_STANDBY, 20);
    check({mode_o, reg_access_o, drive_o.led_sink_output_en}, {LDMS_STANDBY, 2'b10}, "stby");
  endtask
  task automatic t_run();
    ctrl_i.chip_run_en = 1'b1;
    wait_mode(LDMS_NORMAL, 4);
    check({mode_o, drive_o.led_sink_output_en}, {LDMS_NORMAL, 1'b1}, "normal");
    check(drive_o.cur_limit, 9'h0ff, "low range");
    ctrl_i.cur_range_sel = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    check(drive_o.cur_limit, 9'h15e, "high range");
    ctrl_i.chip_run_en = 1'b0;
    wait_mode(LDMS_STANDBY, 4);
    check({mode_o, drive_o.led_sink_output_en}, {LDMS_STANDBY, 1'b0}, "run off");
    ctrl_i.chip_run_en = 1'b1;
    wait_mode(LDMS_NORMAL, 4);
  endtask
  task automatic t_psave();
    int s0;
    ctrl_i.auto_sleep_en = 1'b1;
    for (int k = 0; k < 6; k++) begin
      act[4*k+3] = 1'b1;
      @(negedge clk_sys_i);
      act[4*k+3] = 1'b0;
      repeat (OFFC - 10) @(negedge clk_sys_i);
    end
    check(mode_o, LDMS_NORMAL, "activity restarts timer");
    // dark for exactly the interval: not yet asleep, not yet armed
    repeat (OFFC - 40) @(negedge clk_sys_i);
    check({mode_o, sleep_armed_o}, {LDMS_NORMAL, 1'b0}, "not asleep early");
    wait_mode(LDMS_PSAVE, 15);
    check({mode_o, drive_o.analog_en, reg_access_o, sleep_armed_o}, {LDMS_PSAVE, 3'b011},
          "psave");
    s0 = n_sta;
    fork
      m.start(700);
      begin
        wait_mode(LDMS_NORMAL, 200);
        check(mode_o, LDMS_NORMAL, "wake on start");
        act[0] = 1'b1;
      end
    join
    m.wbyte(8'ha5, 700);
    check(bus_busy_o, 1'b1, "busy in frame");
    m.stop(700);
    repeat (30) @(negedge clk_sys_i);
    check({bus_busy_o, 11'(n_sta - s0)}, {1'b0, 11'd1}, "free after stop, one start");
  endtask
  task automatic t_rep();
    int s0, p0, r0;
    s0 = n_sta;
    p0 = n_sto;
    r0 = n_rep;
    m.start(2000);
    m.wbyte(8'h50, 2000);
    m.start(2000);
    check(bus_busy_o, 1'b1, "busy across repeat");
    m.wbyte(8'h51, 2000);
    m.stop(2000);
    repeat (30) @(negedge clk_sys_i);
    check({4'(n_rep - r0), 4'(n_sta - s0), 4'(n_sto - p0)}, {4'd1, 4'd2, 4'd1},
          "repeat start");
  endtask
  task automatic t_soft();
    soft_wr(8'h7e);
    repeat (3) @(negedge clk_sys_i);
    check(mode_o, LDMS_NORMAL, "other code ignored");
    soft_wr(8'hff);
    wait_mode(LDMS_INIT, 4);
    check(mode_o, LDMS_INIT, "soft reset");
    supply_low_lockout_i = 1'b1;
    repeat (40) @(negedge clk_sys_i);
    check({mode_o, drive_o.regs_rst}, {LDMS_INIT, 1'b1}, "held in init");
    en_pin_i = 1'b0;
    wait_mode(LDMS_SHUTDOWN, 6);
    check(mode_o, LDMS_SHUTDOWN, "enable beats supply low");
    en_pin_i = 1'b1;
    supply_low_lockout_i = 1'b0;
    wait_mode(LDMS_NORMAL, 40);
  endtask
  task automatic t_therm();
    temp_hot_i = 1'b1;
    wait_mode(LDMS_TSD, 6);
    check({mode_o, drive_o.led_sink_output_en, drive_o.analog_en}, {LDMS_TSD, 2'b01},
          "thermal off");
    temp_hot_i = 1'b0;
    temp_cool_i = 1'b1;
    wait_mode(LDMS_NORMAL, 6);
    check(mode_o, LDMS_NORMAL, "cooled");
    temp_cool_i = 1'b0;
  endtask

  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_power();
    t_run();
    t_psave();
    t_rep();
    t_soft();
    t_therm();
    print_verdict();
  end
  initial begin
    #600000;
    errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule // testbench

//--- hw/ldms_evt_cross.sv
// Purpose: per bit toggle crossing of one cycle events
// Assumes: events on one bit spaced by several destination cycles
// Notes:   output pulse is one destination cycle, from a flop
`timescale 1ns/1ps

module ldms_evt_cross #(
  parameter int unsigned W = 1
) (
  // clocks and reset
  input  wire logic         clk_src_i,
  input  wire logic         clk_dst_i,
  input  wire logic         rst_n_i,
  // events
  input  wire logic [W-1:0] pulse_i,
  output logic      [W-1:0] pulse_o
);

  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    logic tog_r;
    logic meta_r;
    logic sync_r;
    logic seen_r;
    // source side toggle per event
    always_ff @(posedge clk_src_i or negedge rst_n_i) begin
      if (!rst_n_i) tog_r <= 1'b0;
      else          tog_r <= tog_r ^ pulse_i[i];
    end
    // destination side sync and edge to pulse
    always_ff @(posedge clk_dst_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_r     <= 1'b0;
        sync_r     <= 1'b0;
        seen_r     <= 1'b0;
        pulse_o[i] <= 1'b0;
      end else begin
        meta_r     <= tog_r;
        sync_r     <= meta_r;
        seen_r     <= sync_r;
        pulse_o[i] <= sync_r ^ seen_r;
      end
    end
  end

endmodule // ldms_evt_cross

//--- hw/ldms_pkg.sv
// Purpose: shared constants and types of the led driver mode sequencer
// Assumes: system clock at 100 MHz, link sampling clock free running
// Notes:   every offset and cycle count lives here, with the mode and drive reset values

package ldms_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_SYS_MHZ = 100;
  localparam int unsigned OFF_TIME_MS = 30;
  localparam int unsigned OFF_CYCLES  = OFF_TIME_MS * 1000 * CLK_SYS_MHZ;
  localparam int unsigned OFF_CNT_W   = 22;
  localparam logic [3:0]  INIT_CYCLES = 4'h8;

  // ==========================================================
  // codes and values
  localparam logic [7:0] SOFT_RST_CODE = 8'hff;
  localparam logic [8:0] CUR_LO_DMA    = 9'h0ff; // 25.5 mA in 0.1 mA steps
  localparam logic [8:0] CUR_HI_DMA    = 9'h15e; // 35.0 mA in 0.1 mA steps
  localparam int unsigned LED_OUTS     = 24;

  // ==========================================================
  // pin, link and event vector positions
  localparam int unsigned PIN_EN   = 0;
  localparam int unsigned PIN_LOWV = 1;
  localparam int unsigned PIN_HOT  = 2;
  localparam int unsigned PIN_COOL = 3;
  localparam int unsigned PIN_W    = 4;
  localparam int unsigned LNK_SCL  = 0;
  localparam int unsigned LNK_SDA  = 1;
  localparam int unsigned EVT_STA  = 0;
  localparam int unsigned EVT_STO  = 1;
  localparam int unsigned EVT_RSTA = 2;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    LDMS_SHUTDOWN = 3'h0,
    LDMS_INIT     = 3'h1,
    LDMS_NORMAL   = 3'h2,
    LDMS_STANDBY  = 3'h3,
    LDMS_PSAVE    = 3'h4,
    LDMS_TSD      = 3'h5
  } ldms_mode_e;

  typedef struct packed {
    logic chip_run_en;
    logic auto_sleep_en;
    logic cur_range_sel;
  } ldms_ctrl_s;

  typedef struct packed {
    logic       led_sink_output_en;
    logic       analog_en;
    logic       regs_rst;
    logic [8:0] cur_limit;
  } ldms_drive_s;

  localparam ldms_mode_e  RST_MODE  = LDMS_SHUTDOWN;
  localparam ldms_drive_s RST_DRIVE = '{1'b0, 1'b0, 1'b0, CUR_LO_DMA};

endpackage

//--- hw/ldms_sync.sv
// Purpose: two flop level synchroniser
// Assumes: inputs are quasi static levels
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps

module ldms_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // ==========================================================
  // two stage capture
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule // ldms_sync

//--- hw/ldms_top.sv
// Purpose: operating mode sequencer of a multi channel led sink driver
// Assumes: register file and pwm logic run on clk_sys_i; pins are async
// Notes:   bus framing is watched on a free running link sampling clock
`timescale 1ns/1ps

module ldms_top #(
  parameter int unsigned LEDS         = ldms_pkg::LED_OUTS,
  parameter int unsigned OFF_CYCLES_P = ldms_pkg::OFF_CYCLES,
  parameter logic [3:0]  INIT_LEN     = ldms_pkg::INIT_CYCLES
) (
  // system clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  // link sampling clock
  input  wire logic                 clk_link_i,
  // device pins, asynchronous
  input  wire logic                 en_pin_i,
  input  wire logic                 supply_low_lockout_i,
  input  wire logic                 temp_hot_i,
  input  wire logic                 temp_cool_i,
  // serial bus lines, sampled on link clock
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  // control bits from register file
  input  wire ldms_pkg::ldms_ctrl_s ctrl_i,
  input  wire logic                 rst_reg_wr_i,
  input  wire logic [7:0]           rst_reg_data_i,
  // per channel activity from pwm logic
  input  wire logic [LEDS-1:0]      led_sink_output_act_i,
  // mode and drive controls
  output ldms_pkg::ldms_mode_e      mode_o,
  output ldms_pkg::ldms_drive_s     drive_o,
  output logic                      reg_access_o,
  output logic                      sleep_armed_o,
  // bus framing status, system clock
  output logic                      bus_busy_o,
  output logic                      start_o,
  output logic                      stop_o,
  output logic                      rep_start_o
);

  import ldms_pkg::*;

  // ==========================================================
  // declarations
  logic [PIN_W-1:0]     pin_raw;
  logic [PIN_W-1:0]     pin_s;
  logic                 en_s;
  logic                 lowv_s;
  logic                 hot_s;
  logic                 cool_s;
  logic [1:0]           lnk_raw;
  logic [1:0]           lnk_s;
  logic                 scl_d_r;
  logic                 sda_d_r;
  logic                 sta_det;
  logic                 sto_det;
  logic                 busy_lnk_r;
  logic [2:0]           evt_lnk;
  logic [2:0]           evt_sys;
  logic                 busy_sys;
  logic                 soft_rst;
  logic                 any_act;
  logic [OFF_CNT_W-1:0] off_cnt_r;
  logic [OFF_CNT_W-1:0] off_cnt_nxt;
  logic                 off_done;
  logic                 sleep_ok;
  logic [3:0]           init_cnt_r;
  logic [3:0]           init_cnt_nxt;
  logic                 init_done;
  logic                 wake;
  ldms_mode_e           mode_r;
  ldms_mode_e           mode_nxt;
  ldms_drive_s          drive_r;
  ldms_drive_s          drive_nxt;
  logic                 access_r;
  logic                 access_nxt;

  // ==========================================================
  // pin synchronisers, system domain

  // gather async pins into one vector
  always_comb begin
    pin_raw           = '0;
    pin_raw[PIN_EN]   = en_pin_i;
    pin_raw[PIN_LOWV] = supply_low_lockout_i;
    pin_raw[PIN_HOT]  = temp_hot_i;
    pin_raw[PIN_COOL] = temp_cool_i;
  end

  ldms_sync #(
    .W (PIN_W)
  ) u_pin_sync (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_i),
    .d_i     (pin_raw),
    .q_o     (pin_s)
  );

  // named views of synchronised pins
  assign en_s   = pin_s[PIN_EN];
  assign lowv_s = pin_s[PIN_LOWV];
  assign hot_s  = pin_s[PIN_HOT];
  assign cool_s = pin_s[PIN_COOL];

  // ==========================================================
  // link domain: start and stop framing

  // bus lines into link domain
  assign lnk_raw[LNK_SCL] = scl_i;
  assign lnk_raw[LNK_SDA] = sda_i;

  ldms_sync #(
    .W (2)
  ) u_lnk_sync (
    .clk_i   (clk_link_i),
    .rst_n_i (rst_n_i),
    .d_i     (lnk_raw),
    .q_o     (lnk_s)
  );

  // previous sample of both lines, idle high
  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= lnk_s[LNK_SCL];
      sda_d_r <= lnk_s[LNK_SDA];
    end
  end

  // data moving while clock high is framing, never data
  assign sta_det = scl_d_r && lnk_s[LNK_SCL]
                   && sda_d_r && !lnk_s[LNK_SDA];
  assign sto_det = scl_d_r && lnk_s[LNK_SCL]
                   && !sda_d_r && lnk_s[LNK_SDA];

  // busy from any start, free only after a stop
  always_ff @(posedge clk_link_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_lnk_r <= 1'b0;
    end else if (sta_det) begin
      busy_lnk_r <= 1'b1;
    end else if (sto_det) begin
      busy_lnk_r <= 1'b0;
    end
  end

  // events to cross; repeated start also raises plain start
  assign evt_lnk[EVT_STA]  = sta_det;
  assign evt_lnk[EVT_STO]  = sto_det;
  assign evt_lnk[EVT_RSTA] = sta_det && busy_lnk_r;

  // ==========================================================
  // crossings into system domain

  ldms_evt_cross #(
    .W (3)
  ) u_evt_cross (
    .clk_src_i (clk_link_i),
    .clk_dst_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pulse_i   (evt_lnk),
    .pulse_o   (evt_sys)
  );

  ldms_sync #(
    .W (1)
  ) u_busy_sync (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_i),
    .d_i     (busy_lnk_r),
    .q_o     (busy_sys)
  );

  // framing status out
  assign bus_busy_o  = busy_sys;
  assign start_o     = evt_sys[EVT_STA];
  assign stop_o      = evt_sys[EVT_STO];
  assign rep_start_o = evt_sys[EVT_RSTA];

  // ==========================================================
  // request decode

  // soft reset only on the exact reset code
  assign soft_rst = rst_reg_wr_i && (rst_reg_data_i == SOFT_RST_CODE);

  // any channel conducting
  assign any_act = |led_sink_output_act_i;

  // wake on framing start, first or repeated alike
  assign wake = evt_sys[EVT_STA];

  // ==========================================================
  // all outputs off timer

  // counts only in normal while every output is dark
  always_comb begin
    off_cnt_nxt = off_cnt_r;
    if (mode_r != LDMS_NORMAL || any_act) begin
      off_cnt_nxt = '0;
    end else if (!off_done) begin
      off_cnt_nxt = off_cnt_r + OFF_CNT_W'(1);
    end
  end

  // timer register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) off_cnt_r <= '0;
    else          off_cnt_r <= off_cnt_nxt;
  end

  // saturates after exactly the full interval of darkness
  assign off_done = (off_cnt_r == OFF_CNT_W'(OFF_CYCLES_P));
  assign sleep_ok = ctrl_i.auto_sleep_en && off_done && !any_act;

  // ==========================================================
  // initialization length

  // restarts while supply is low so the reset stays held
  always_comb begin
    init_cnt_nxt = init_cnt_r;
    if (mode_r != LDMS_INIT || lowv_s || soft_rst) begin
      init_cnt_nxt = '0;
    end else if (!init_done) begin
      init_cnt_nxt = init_cnt_r + 4'h1;
    end
  end

  // init counter register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) init_cnt_r <= '0;
    else          init_cnt_r <= init_cnt_nxt;
  end

  assign init_done = (init_cnt_r == INIT_LEN);

  // ==========================================================
  // mode state machine

  // next mode with fixed precedence of entry conditions
  always_comb begin
    mode_nxt = mode_r;
    if (!en_s) begin
      mode_nxt = LDMS_SHUTDOWN;
    end else if (lowv_s || soft_rst) begin
      mode_nxt = LDMS_INIT;
    end else begin
      unique case (mode_r)
        LDMS_SHUTDOWN: begin
          mode_nxt = LDMS_INIT;
        end
        LDMS_INIT: begin
          if (init_done) mode_nxt = LDMS_STANDBY;
        end
        LDMS_NORMAL: begin
          if (hot_s) begin
            mode_nxt = LDMS_TSD;
          end else if (!ctrl_i.chip_run_en) begin
            mode_nxt = LDMS_STANDBY;
          end else if (sleep_ok) begin
            mode_nxt = LDMS_PSAVE;
          end
        end
        LDMS_STANDBY: begin
          if (hot_s) begin
            mode_nxt = LDMS_TSD;
          end else if (ctrl_i.chip_run_en) begin
            mode_nxt = LDMS_NORMAL;
          end
        end
        LDMS_PSAVE: begin
          if (hot_s) begin
            mode_nxt = LDMS_TSD;
          end else if (!ctrl_i.chip_run_en) begin
            mode_nxt = LDMS_STANDBY;
          end else if (wake) begin
            mode_nxt = LDMS_NORMAL;
          end
        end
        LDMS_TSD: begin
          // leave only on the low threshold for hysteresis
          if (cool_s && !hot_s) mode_nxt = LDMS_NORMAL;
        end
        default: begin
          mode_nxt = LDMS_SHUTDOWN;
        end
      endcase
    end
  end

  // mode register; reset stands for supply power up
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) mode_r <= RST_MODE;
    else          mode_r <= mode_nxt;
  end

  assign mode_o = mode_r;

  // ==========================================================
  // drive controls

  // decode of controls from the coming mode
  always_comb begin
    drive_nxt = RST_DRIVE;
    drive_nxt.led_sink_output_en = (mode_nxt == LDMS_NORMAL);
    drive_nxt.analog_en = (mode_nxt == LDMS_NORMAL)
                          || (mode_nxt == LDMS_TSD);
    drive_nxt.regs_rst  = (mode_nxt == LDMS_INIT);
    drive_nxt.cur_limit = ctrl_i.cur_range_sel ? CUR_HI_DMA
                                               : CUR_LO_DMA;
  end

  // bus register access kept in every mode except shutdown and init
  always_comb begin
    access_nxt = 1'b0;
    unique case (mode_nxt)
      LDMS_NORMAL:  access_nxt = 1'b1;
      LDMS_STANDBY: access_nxt = 1'b1;
      LDMS_PSAVE:   access_nxt = 1'b1;
      LDMS_TSD:     access_nxt = 1'b1;
      default:      access_nxt = 1'b0;
    endcase
  end

  // drive output registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_r  <= RST_DRIVE;
      access_r <= 1'b0;
    end else begin
      drive_r  <= drive_nxt;
      access_r <= access_nxt;
    end
  end

  // sleep armed flag, registered
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) sleep_armed_o <= 1'b0;
    else          sleep_armed_o <= off_done;
  end

  assign drive_o      = drive_r;
  assign reg_access_o = access_r;

endmodule // ldms_top
